// *** pkg/sbs_consts.svh ***
// Purpose: constants of the servo brake and stop sequencer
// Assumes: 40 MHz clk_i, 32-bit classic wishbone register port
// Notes: offsets are byte addresses, one word per register
// Behaviour
// - alarm or servo-off applies the brake
// - overtravel never applies the brake
// - brake routed by terminal select, restart-effective
// - shared terminals driven with or logic
// - stopped motor: brake applies on command cycle
// - stopped motor: power-off delayed by programmed time
// - alarm removes power at once, no delay, except a group two zero-speed stop
// - moving motor: brake when speed below threshold
// - moving motor: brake when wait time expires
// - zero-speed stop, then stopped-motor brake timing
// - servo-off stop mode: db/db, db/coast, coast
// - group one alarms use servo-off stop mode
// - group two alarms use separate stop setting
// - group two zero-speed only in position/speed control
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// register byte offsets
`define SBS_OFS_CMD 8'h00
`define SBS_OFS_DELAY 8'h04
`define SBS_OFS_THRESH 8'h08
`define SBS_OFS_WAIT 8'h0c
`define SBS_OFS_SEL 8'h10
`define SBS_OFS_STATUS 8'h14

// command bits
`define SBS_CMD_ON 0
`define SBS_CMD_OFF 1
`define SBS_CMD_RESTART 2

// select register fields
`define SBS_SEL_TERM_LSB 0
`define SBS_SEL_STOP_LSB 4
`define SBS_SEL_G2 8

// reset values
`define SBS_RST_DELAY 6'h00
`define SBS_RST_THRESH 14'h000a
`define SBS_RST_WAIT 7'h32
`define SBS_RST_TERM 2'h1
`define SBS_RST_STOP 2'h0
`define SBS_RST_G2 1'h0

// legal ranges
`define SBS_MAX_DELAY 6'h32
`define SBS_MAX_THRESH 14'h2710
`define SBS_MIN_WAIT 7'h0a
`define SBS_MAX_WAIT 7'h64

// timing: one setting unit in ms, clock in kHz
`define SBS_UNIT_MS 10
`define SBS_CLK_KHZ 40000
`define SBS_UNIT_CYCLES (`SBS_UNIT_MS * `SBS_CLK_KHZ)

`endif

// *** pkg/sbs_pkg.sv ***
// Purpose: types of the servo brake and stop sequencer
// Assumes: nothing beyond the consts header
// Notes: stop modes follow the select field encoding
package sbs_pkg;
	// sequencer states
	typedef enum logic [2:0] {
		SBS_OFF,
		SBS_ON,
		SBS_DELAY,
		SBS_ZERO,
		SBS_COAST
	} sbs_state_t;

	// servo-off stop method
	typedef enum logic [1:0] {
		SBS_DB_DB = 2'h0,
		SBS_DB_COAST = 2'h1,
		SBS_COAST_COAST = 2'h2
	} sbs_stop_t;
endpackage

// *** pkg/sbs_tmr_if.sv ***
// Purpose: link between sequencer and its unit timer
// Assumes: single clock
// Notes: done is a level until the next start
interface sbs_tmr_if;
	logic start;
	logic [6:0] units;
	logic done;

	modport ctl (output start, output units, input done);
	modport tmr (input start, input units, output done);
endinterface

// *** rtl/sbs_timer.sv ***
// Purpose: countdown in whole setting units
// Assumes: start is a one-cycle pulse
// Notes: zero units gives done two cycles after the start pulse
`include "sbs_consts.svh"

module sbs_timer #(
	parameter int UNIT_CYCLES = `SBS_UNIT_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	sbs_tmr_if.tmr t
);
	logic [31:0] pre;
	logic [6:0] cnt;
	logic run;
	logic done_q;
	wire unit_end = (pre == 32'(UNIT_CYCLES - 1));

	// prescaler restarts with each start so units are whole
	always_ff @(posedge clk_i) begin
		if (rst_i || t.start || unit_end) begin
			pre <= 32'h0;
		end else begin
			pre <= pre + 32'h1;
		end
	end

	// unit countdown
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 7'h0;
			run <= 1'b0;
			done_q <= 1'b0;
		end else if (t.start) begin
			cnt <= t.units;
			run <= 1'b1;
			done_q <= 1'b0;
		end else if (run && cnt == 7'h0) begin
			run <= 1'b0;
			done_q <= 1'b1;
		end else if (run && unit_end) begin
			cnt <= cnt - 7'h1;
		end
	end

	assign t.done = done_q;
endmodule // sbs_timer

// *** rtl/sbs_outmux.sv ***
// Purpose: route brake release onto one of the output terminals
// Assumes: select 0 means unused, 1..N pick a terminal
// Notes: other signals on a terminal are or-ed in
module sbs_outmux #(
	parameter int N_TERM = 3
) (
	// inputs
	input wire logic [1:0] sel_i,
	input wire logic brake_i,
	input wire logic [N_TERM-1:0] other_i,
	// terminal drive
	output logic [N_TERM-1:0] term_o
);
	// one or gate per terminal
	genvar g;
	generate
		for (g = 0; g < N_TERM; g++) begin : g_term
			assign term_o[g] = other_i[g] | (brake_i && sel_i == 2'(g + 1));
		end
	endgenerate
endmodule // sbs_outmux

// *** rtl/sbs_top.sv ***
// Purpose: brake-release and stop-method sequencer of a servo amplifier
// Assumes: speed_i is the measured speed magnitude in mm/s
// Notes: registers on classic wishbone; outputs are flip-flops
`include "sbs_consts.svh"

module sbs_top
	import sbs_pkg::*;
#(
	parameter int UNIT_CYCLES = `SBS_UNIT_CYCLES,
	parameter int N_TERM = 3
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// drive status
	input wire logic alarm_g1_i,
	input wire logic alarm_g2_i,
	input wire logic overtravel_i,
	input wire logic force_ctrl_i,
	input wire logic [13:0] speed_i,
	input wire logic [N_TERM-1:0] other_term_i,
	// drive outputs
	output logic motor_power_o,
	output logic dynamic_braking_o,
	output logic zero_ref_o,
	output logic brake_release_out_o,
	output logic [N_TERM-1:0] term_o
);
	// sequencer state and its unit timer
	sbs_state_t state, next_state;
	sbs_tmr_if tmr ();

	// software settings
	logic [5:0] brake_power_off_delay;
	logic [13:0] brake_speed_threshold;
	logic [6:0] brake_wait_timeout;
	logic [1:0] term_req;
	logic [1:0] stop_req;
	logic g2_req;
	// settings taken over at restart
	logic [1:0] output_terminal_select;
	logic [1:0] servo_off_stop_select;
	logic group_two_stop_select;
	// one-cycle command pulses
	logic servo_on_cmd;
	logic servo_off_cmd;
	logic restart_cmd;
	logic [N_TERM-1:0] term_q;

	// address match per register and byte lanes in use
	wire hit_cmd = adr_i == `SBS_OFS_CMD;
	wire hit_dly = adr_i == `SBS_OFS_DELAY;
	wire hit_thr = adr_i == `SBS_OFS_THRESH;
	wire hit_wait = adr_i == `SBS_OFS_WAIT;
	wire hit_sel = adr_i == `SBS_OFS_SEL;
	wire lo_byte = sel_i[0];
	wire lo_half = sel_i[1:0] == 2'h3;

	// bus decode, writes land on the edge that sees ack
	wire req = cyc_i && stb_i && !ack_o;
	wire wr = cyc_i && stb_i && we_i && ack_o;
	wire wr_cmd = wr && hit_cmd && lo_byte;
	wire wr_dly = wr && hit_dly && lo_byte;
	wire wr_thr = wr && hit_thr && lo_half;
	wire wr_wait = wr && hit_wait && lo_byte;
	wire wr_sel = wr && hit_sel && lo_half;

	// command pulses on the write edge
	assign servo_on_cmd = wr_cmd && dat_i[`SBS_CMD_ON];
	assign servo_off_cmd = wr_cmd && dat_i[`SBS_CMD_OFF];
	assign restart_cmd = wr_cmd && dat_i[`SBS_CMD_RESTART];

	// clamp written values into their legal range
	wire dly_over = dat_i[5:0] > `SBS_MAX_DELAY;
	wire thr_over = dat_i[13:0] > `SBS_MAX_THRESH;
	wire wait_over = dat_i[6:0] > `SBS_MAX_WAIT;
	wire stop_bad = dat_i[`SBS_SEL_STOP_LSB +: 2] == 2'h3;
	wire [5:0] dly_in = dly_over ? `SBS_MAX_DELAY : dat_i[5:0];
	wire [13:0] thr_in = thr_over ? `SBS_MAX_THRESH : dat_i[13:0];
	wire [6:0] wait_hi = wait_over ? `SBS_MAX_WAIT : dat_i[6:0];
	wire [6:0] wait_in = (wait_hi < `SBS_MIN_WAIT) ? `SBS_MIN_WAIT : wait_hi;
	wire [1:0] stop_in = stop_bad ? 2'h2 : dat_i[`SBS_SEL_STOP_LSB +: 2];

	// status word, top bit down; bit 15 mirrors overtravel
	wire [31:0] status_word = {
		16'h0,
		overtravel_i, // [15]
		state, // [14:12]
		3'b0,
		servo_off_stop_select, // [8:7]
		output_terminal_select, // [6:5]
		group_two_stop_select, // [4]
		zero_ref_o, // [3]
		dynamic_braking_o, // [2]
		brake_release_out_o, // [1]
		motor_power_o // [0]
	};

	// pending select word as software wrote it
	wire [31:0] sel_word = {23'h0, g2_req, 2'h0, stop_req, 2'h0, term_req};

	// read mux, unmapped reads give zero
	logic [31:0] rd_mux;
	always_comb begin
		case (adr_i)
			`SBS_OFS_CMD: rd_mux = 32'h0; // commands read as zero
			`SBS_OFS_DELAY: rd_mux = {26'h0, brake_power_off_delay};
			`SBS_OFS_THRESH: rd_mux = {18'h0, brake_speed_threshold};
			`SBS_OFS_WAIT: rd_mux = {25'h0, brake_wait_timeout};
			`SBS_OFS_SEL: rd_mux = sel_word;
			`SBS_OFS_STATUS: rd_mux = status_word;
			default: rd_mux = 32'h0;
		endcase
	end

	// wishbone ack and read data, one wait state
	// req is gated by ack_o so ack never stays high two cycles in a row
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= req;
			dat_o <= req ? rd_mux : 32'h0;
		end
	end

	// settings that take effect immediately
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			brake_power_off_delay <= `SBS_RST_DELAY;
			brake_speed_threshold <= `SBS_RST_THRESH;
			brake_wait_timeout <= `SBS_RST_WAIT;
		end else begin
			if (wr_dly) brake_power_off_delay <= dly_in;
			if (wr_thr) brake_speed_threshold <= thr_in;
			if (wr_wait) brake_wait_timeout <= wait_in;
		end
	end

	// restart-effective settings: pending copy and active copy
	// copied only while off so a running axis keeps its stop rule
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_req <= `SBS_RST_TERM;
			stop_req <= `SBS_RST_STOP;
			g2_req <= `SBS_RST_G2;
			output_terminal_select <= `SBS_RST_TERM;
			servo_off_stop_select <= `SBS_RST_STOP;
			group_two_stop_select <= `SBS_RST_G2;
		end else begin
			if (wr_sel) begin
				term_req <= dat_i[`SBS_SEL_TERM_LSB +: 2];
				stop_req <= stop_in;
				g2_req <= dat_i[`SBS_SEL_G2];
			end
			if (restart_cmd && state == SBS_OFF) begin
				output_terminal_select <= term_req;
				servo_off_stop_select <= stop_req;
				group_two_stop_select <= g2_req;
			end
		end
	end

	// motion and alarm conditions
	wire alarm = alarm_g1_i || alarm_g2_i;
	wire moving = speed_i != 14'h0;
	wire below_thr = speed_i < brake_speed_threshold;
	// group two zero-speed only outside force control
	wire g2_allowed = !force_ctrl_i;
	wire g2_zero = alarm_g2_i && !group_two_stop_select && g2_allowed;
	// group one, or group two set to db/coast, use servo-off mode
	wire use_off_mode = !g2_zero;

	// timer starts on entry to the delay or to coasting
	// done is a level, but every start clears it, so it is never stale
	wire start_delay = state == SBS_ON && next_state == SBS_DELAY;
	wire start_coast = state == SBS_ON && next_state == SBS_COAST;
	assign tmr.start = start_delay || start_coast;
	assign tmr.units = start_delay ? 7'(brake_power_off_delay) : brake_wait_timeout;

	sbs_timer #(
		.UNIT_CYCLES(UNIT_CYCLES)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.t(tmr)
	);

	// next state
	always_comb begin
		next_state = state;
		case (state)
			SBS_OFF: begin
				if (servo_on_cmd && !alarm) next_state = SBS_ON;
			end
			SBS_ON: begin
				// overtravel is not a stop cause here
				// an alarm outranks a servo-off in the same cycle
				if (alarm && g2_zero) begin
					next_state = SBS_ZERO;
				end else if (alarm) begin
					next_state = moving ? SBS_COAST : SBS_OFF;
				end else if (servo_off_cmd) begin
					next_state = moving ? SBS_COAST : SBS_DELAY;
				end
			end
			SBS_DELAY: begin
				// an alarm cuts the delay short
				if (alarm || tmr.done) next_state = SBS_OFF;
			end
			SBS_ZERO: begin
				// once at rest, stopped timing with alarm: power off at once
				if (!moving) next_state = SBS_OFF;
			end
			SBS_COAST: begin
				// whichever of speed and wait comes first
				if (below_thr) next_state = SBS_OFF;
				else if (tmr.done) next_state = SBS_OFF;
			end
			default: next_state = SBS_OFF;
		endcase
	end

	// power decode from next state
	wire power_run = next_state == SBS_ON || next_state == SBS_DELAY;
	wire power_zero = next_state == SBS_ZERO;
	wire next_power = power_run || power_zero;
	// brake held released while running alarm-free, coasting or stopping at zero speed
	wire brake_run = next_state == SBS_ON && !alarm;
	wire brake_coast = next_state == SBS_COAST;
	wire brake_zero = next_state == SBS_ZERO;
	wire next_brake = brake_run || brake_coast || brake_zero;
	wire next_stopping = next_state == SBS_COAST;
	// dynamic brake per stop mode
	logic next_db;
	always_comb begin
		next_db = 1'b0;
		if (!next_power && use_off_mode) begin
			case (servo_off_stop_select)
				SBS_DB_DB: next_db = 1'b1;
				SBS_DB_COAST: next_db = next_stopping;
				default: next_db = 1'b0;
			endcase
		end else if (!next_power) begin
			// after a zero-speed stop the servo-off after-mode holds
			next_db = servo_off_stop_select == SBS_DB_DB;
		end
	end

	// sequencer state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SBS_OFF;
		end else begin
			state <= next_state;
		end
	end

	// drive registers, loaded from the next-state decode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			motor_power_o <= 1'b0;
			brake_release_out_o <= 1'b0;
			dynamic_braking_o <= 1'b0;
			zero_ref_o <= 1'b0;
		end else begin
			motor_power_o <= next_power;
			brake_release_out_o <= next_brake;
			dynamic_braking_o <= next_db;
			zero_ref_o <= next_state == SBS_ZERO;
		end
	end

	// terminal routing
	// routing uses the restart copy of the select, never the pending one
	logic [N_TERM-1:0] term_next;
	sbs_outmux #(
		.N_TERM(N_TERM)
	) u_outmux (
		.sel_i(output_terminal_select),
		.brake_i(next_brake),
		.other_i(other_term_i),
		.term_o(term_next)
	);

	// registered terminal drive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_q <= {N_TERM{1'b0}};
		end else begin
			term_q <= term_next;
		end
	end

	assign term_o = term_q;
endmodule // sbs_top

// *** tb/sbs_top_assertions.sv ***
// Purpose: port assertions of the brake sequencer
// Assumes: bound to sbs_top, unit length passed in
// Notes: bus checks assume the master holds requests until ack
module sbs_top_assertions #(
	parameter int UNIT_CYCLES = 10,
	parameter int N_TERM = 3
) (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// drive side
	input wire logic alarm_g1_i,
	input wire logic alarm_g2_i,
	input wire logic overtravel_i,
	input wire logic force_ctrl_i,
	input wire logic [13:0] speed_i,
	input wire logic [N_TERM-1:0] other_term_i,
	input wire logic motor_power_o,
	input wire logic zero_ref_o,
	input wire logic brake_release_out_o,
	input wire logic [N_TERM-1:0] term_o
);
	localparam int COAST_MAX = 102 * UNIT_CYCLES;
	logic [31:0] coast_cnt;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// cycles coasting unpowered with the brake still released
	always_ff @(posedge clk_i) begin
		if (rst_i || motor_power_o || !brake_release_out_o) begin
			coast_cnt <= 32'h0;
		end else begin
			coast_cnt <= coast_cnt + 32'h1;
		end
	end
	// bus answer timing
	AST_ACK_LAT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data not idle");
	// brake and power sequencing
	AST_OFF_BRAKE: assert property (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00
		&& sel_i[0] && dat_i[1] && !dat_i[0] && speed_i == 14'h0 |=> !brake_release_out_o)
		else $error("brake not applied on servo off");
	AST_G1_POWER: assert property ($rose(alarm_g1_i) |=> !motor_power_o)
		else $error("power kept on alarm");
	AST_G1_BRAKE: assert property (alarm_g1_i && speed_i == 14'h0
		|=> ##[0:1] !brake_release_out_o)
		else $error("brake kept on alarm");
	AST_OT_HOLD: assert property (brake_release_out_o && motor_power_o && !zero_ref_o
		&& overtravel_i && !alarm_g1_i && !alarm_g2_i && !cyc_i |=> brake_release_out_o)
		else $error("overtravel applied brake");
	AST_REL_POWER: assert property ($rose(brake_release_out_o) |-> motor_power_o
		&& !alarm_g1_i)
		else $error("release without power");
	AST_TERM_OR: assert property (|other_term_i
		|=> (term_o & $past(other_term_i)) == $past(other_term_i))
		else $error("terminal or lost");
	AST_G2_FORCE: assert property ($rose(alarm_g2_i) && force_ctrl_i && !zero_ref_o
		|=> !zero_ref_o)
		else $error("zero speed in force control");
	AST_WAIT_MAX: assert property (coast_cnt <= COAST_MAX)
		else $error("coast wait overrun");
	// main scenarios
	cover property (zero_ref_o);
	cover property ($fell(brake_release_out_o) && !motor_power_o);
	cover property (term_o[N_TERM-1]);
endmodule // sbs_top_assertions

// *** tb/sbs_host_model.sv ***
// Purpose: host controller model issuing servo commands
// Assumes: one classic wishbone cycle per request
// Notes: released write data is inverted, never left stale
module sbs_host_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench request
	input wire logic req_i,
	input wire logic rw_i,
	input wire logic [7:0] ra_i,
	input wire logic [31:0] rd_i,
	output logic done_o = 1'b0,
	output logic [31:0] q_o = 32'h0,
	// wishbone master
	output logic cyc_o = 1'b0,
	output logic stb_o = 1'b0,
	output logic we_o = 1'b0,
	output logic [7:0] adr_o = 8'h0,
	output logic [3:0] sel_o = 4'hf,
	output logic [31:0] dat_o = 32'h0,
	input wire logic ack_i,
	input wire logic [31:0] dat_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// hold the request until ack, then release and report
	always @(posedge clk_i) begin
		if (rst_i) begin
			cyc_o <= 1'b0;
			stb_o <= 1'b0;
			done_o <= 1'b0;
		end else if (cyc_o && ack_i) begin
			cyc_o <= 1'b0;
			stb_o <= 1'b0;
			we_o <= 1'b0;
			dat_o <= ~dat_o;
			q_o <= dat_i;
			done_o <= 1'b1;
		end else if (req_i && !cyc_o && !done_o) begin
			cyc_o <= 1'b1;
			stb_o <= 1'b1;
			we_o <= rw_i;
			adr_o <= ra_i;
			dat_o <= rd_i;
		end else if (!req_i) begin
			done_o <= 1'b0;
		end
	end
endmodule // sbs_host_model

// *** tb/tb_top.sv ***
// Purpose: self-checking bench of the brake sequencer
// Assumes: unit time cut to 10 clock cycles
// Notes: all bus traffic goes through the host model
`include "sbs_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int UC = 10;
	localparam logic [7:0] RA [6] = '{`SBS_OFS_DELAY, `SBS_OFS_THRESH, `SBS_OFS_WAIT,
		`SBS_OFS_SEL, `SBS_OFS_STATUS, 8'h3c};
	localparam logic [31:0] RX [6] = '{32'h0, 32'ha, 32'h32, 32'h1, 32'h24, 32'h0};
	localparam logic [31:0] WV [3] = '{32'h3f, 32'h3fff, 32'h1};
	localparam logic [31:0] WX [3] = '{32'h32, 32'h2710, 32'ha};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i, stb_i, we_i, ack_o, done;
	logic [7:0] adr_i;
	logic [3:0] sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [31:0] rd = 32'h0;
	logic req = 1'b0;
	logic rw = 1'b0;
	logic [7:0] ra = 8'h0;
	logic alarm_g1_i = 1'b0, alarm_g2_i = 1'b0, overtravel_i = 1'b0, force_ctrl_i = 1'b0;
	logic [13:0] speed_i = 14'h0;
	logic [2:0] other_term_i = 3'h0;
	logic motor_power_o, dynamic_braking_o, zero_ref_o, brake_release_out_o;
	logic [2:0] term_o;
	int err_count = 0;
	int n_checks = 0;
	// design with short units, host on its bus
	sbs_top #(.UNIT_CYCLES(UC)) u_sbs_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i, .dat_i, .dat_o, .ack_o, .alarm_g1_i, .alarm_g2_i, .overtravel_i,
		.force_ctrl_i, .speed_i, .other_term_i, .motor_power_o, .dynamic_braking_o,
		.zero_ref_o, .brake_release_out_o, .term_o);
	sbs_host_model u_sbs_host_model (.clk_i, .rst_i, .req_i(req), .rw_i(rw), .ra_i(ra),
		.rd_i(rd), .done_o(done), .q_o(q), .cyc_o(cyc_i), .stb_o(stb_i), .we_o(we_i),
		.adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i), .ack_i(ack_o), .dat_i(dat_o));
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one bus transfer through the host, read data lands in q
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		req <= 1'b1;
		rw <= w;
		ra <= a;
		rd <= d;
		// let the host drop done of the previous transfer first
		@(posedge clk_i);
		while (done !== 1'b1) @(posedge clk_i);
		req <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic t_regs();
		foreach (RA[i]) begin
			wb(1'b0, RA[i], 32'h0);
			chk("reset value", RX[i], q);
		end
		foreach (WV[i]) begin
			wb(1'b1, RA[i], WV[i]);
			wb(1'b0, RA[i], 32'h0);
			chk("clamped value", WX[i], q);
		end
	endtask
	task automatic t_stopped();
		wb(1'b1, `SBS_OFS_DELAY, 32'h2);
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		tick(2);
		chk("brake on", 32'h1, brake_release_out_o);
		chk("term on", 32'h1, term_o);
		wb(1'b1, `SBS_OFS_CMD, 32'h2);
		chk("brake off", 32'h0, brake_release_out_o);
		tick(2 * UC - 3);
		chk("power held", 32'h1, motor_power_o);
		tick(3 * UC);
		chk("power off", 32'h0, motor_power_o);
	endtask
	task automatic t_alarm();
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		alarm_g1_i <= 1'b1;
		tick(3);
		chk("alarm power", 32'h0, motor_power_o);
		chk("alarm brake", 32'h0, brake_release_out_o);
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		tick(2);
		chk("on in alarm", 32'h0, brake_release_out_o);
		alarm_g1_i <= 1'b0;
	endtask
	task automatic t_coast();
		wb(1'b1, `SBS_OFS_THRESH, 32'ha);
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		tick(5 * UC);
		speed_i <= 14'd500;
		wb(1'b1, `SBS_OFS_CMD, 32'h2);
		chk("coast db", 32'h1, dynamic_braking_o);
		tick(6 * UC);
		chk("coast brake", 32'h1, brake_release_out_o);
		tick(7 * UC);
		chk("wait brake", 32'h0, brake_release_out_o);
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		alarm_g1_i <= 1'b1;
		tick(20);
		chk("g1 coast", 32'h1, brake_release_out_o);
		speed_i <= 14'd9;
		tick(3);
		chk("slow brake", 32'h0, brake_release_out_o);
		alarm_g1_i <= 1'b0;
		speed_i <= 14'h0;
	endtask
	task automatic t_ot_g2();
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		overtravel_i <= 1'b1;
		tick(20);
		chk("overtravel", 32'h1, brake_release_out_o);
		overtravel_i <= 1'b0;
		speed_i <= 14'd300;
		alarm_g2_i <= 1'b1;
		tick(3);
		chk("zero ref", 32'h1, zero_ref_o);
		chk("zero power", 32'h1, motor_power_o);
		speed_i <= 14'h0;
		tick(5 * UC);
		chk("zero done", 32'h0, motor_power_o | brake_release_out_o);
		alarm_g2_i <= 1'b0;
		force_ctrl_i <= 1'b1;
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		speed_i <= 14'd300;
		alarm_g2_i <= 1'b1;
		tick(3);
		chk("force ref", 32'h0, zero_ref_o);
		alarm_g2_i <= 1'b0;
		force_ctrl_i <= 1'b0;
		speed_i <= 14'h0;
		tick(5);
	endtask
	task automatic t_restart();
		wb(1'b1, `SBS_OFS_SEL, 32'h123);
		wb(1'b1, `SBS_OFS_CMD, 32'h4);
		wb(1'b0, `SBS_OFS_STATUS, 32'h0);
		chk("sel active", 32'h170, q & 32'h1f0);
		wb(1'b1, `SBS_OFS_CMD, 32'h1);
		tick(2);
		chk("term three", 32'h4, term_o);
		other_term_i <= 3'h1;
		tick(2);
		chk("term or", 32'h5, term_o);
		other_term_i <= 3'h0;
		speed_i <= 14'd300;
		alarm_g2_i <= 1'b1;
		tick(3);
		chk("g2 no zero", 32'h0, zero_ref_o);
		chk("coast no db", 32'h0, dynamic_braking_o);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	initial begin
		tick(2);
		rst_i <= 1'b0;
		tick(1);
		t_regs();
		t_stopped();
		t_alarm();
		t_coast();
		t_ot_g2();
		t_restart();
		conclude();
	end
	// watchdog against a hung handshake
	initial begin
		tick(20000);
		err_count++;
		conclude();
	end
endmodule // tb_top
bind sbs_top sbs_top_assertions #(.UNIT_CYCLES(UNIT_CYCLES), .N_TERM(N_TERM)) u_chk (.clk_i,
	.rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .alarm_g1_i,
	.alarm_g2_i, .overtravel_i, .force_ctrl_i, .speed_i, .other_term_i, .motor_power_o,
	.zero_ref_o, .brake_release_out_o, .term_o);
